// [hw/dos_speed_cmp.sv]
`timescale 1ns/10ps
`default_nettype none

// Registered speed, position and process comparisons shared by all outputs
module dos_speed_cmp
  import dos_pkg::*;
(
  // Clock and synchronised reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  // Thresholds from the setting registers
  input  wire logic [SPD_W-1:0]        standstill_speed_limit,
  input  wire logic [SPD_W-1:0]        speed_match_band,
  input  wire logic [SPD_W-1:0]        set_speed_limit,
  input  wire logic [SPD_W-1:0]        process_error_tolerance,
  input  wire logic [SPD_W-1:0]        position_window,
  // Live drive measurements, signed rpm or counts
  input  wire logic                    vf_mode,
  input  wire logic signed [SPD_W-1:0] motor_speed,
  input  wire logic signed [SPD_W-1:0] speed_demand,
  input  wire logic signed [SPD_W-1:0] speed_ref,
  input  wire logic signed [SPD_W-1:0] process_error,
  input  wire logic signed [SPD_W-1:0] position_error,
  // Comparison flags, one cycle behind the inputs
  output logic [FLG_W-1:0]             flags
);

  typedef struct packed {
    logic [FLG_W-1:0] flags;
  } dos_cmp_st_t;

  dos_cmp_st_t st_r;
  dos_cmp_st_t st_nxt;

  // Magnitude kept one bit wider so that the most negative value survives
  function automatic logic [SPD_W:0] mag(input logic signed [SPD_W:0] v);
    mag = v[SPD_W] ? (~v + 1'b1) : v;
  endfunction

  always_comb
  begin
    logic signed [SPD_W:0] speed_used;
    logic signed [SPD_W:0] speed_err;
    logic [SPD_W:0]        spd_mag;
    logic [SPD_W:0]        msr_mag;
    speed_used = vf_mode ? {speed_demand[SPD_W-1], speed_demand} : {motor_speed[SPD_W-1], motor_speed};
    speed_err  = {speed_ref[SPD_W-1], speed_ref} - speed_used;
    spd_mag    = mag(speed_used);
    msr_mag    = mag({motor_speed[SPD_W-1], motor_speed});
    st_nxt     = st_r;
    st_nxt.flags[FLG_ZERO]    = spd_mag < {1'b0, standstill_speed_limit};
    st_nxt.flags[FLG_AT_SPD]  = mag(speed_err) < {1'b0, speed_match_band};
    st_nxt.flags[FLG_SET_SPD] = spd_mag > {1'b0, set_speed_limit};
    st_nxt.flags[FLG_AT_POS]  = (mag({position_error[SPD_W-1], position_error}) <= {1'b0, position_window})
                                && (msr_mag <= {1'b0, standstill_speed_limit});
    st_nxt.flags[FLG_PROC]    = mag({process_error[SPD_W-1], process_error}) > {1'b0, process_error_tolerance};
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign flags = st_r.flags;

endmodule

`default_nettype wire

// [hw/dos_top.sv]
//
// Behaviour
// - code 15 asserts the output while the braking transistor is on.
// - code 16 asserts while current foldback acts, only in V/Hz operation.
// - code 17 asserts while a tripping fault is present.
// - code 18 asserts while a non-tripping alarm is present.
// - codes 19 and 20 follow forward and reverse run commands.
// - codes 21 and 22 follow actual forward and reverse rotation.
// - code 23 asserts when process error magnitude exceeds its tolerance.
// - code 24 output follows the network command bit unchanged.
// - code 25 asserts when position error and speed are both within limits.
// - code 26 asserts when position error or speed exceeds its limit.
// - codes 27 and 28 pass through the PLC and clock module levels.
// - code 29 asserts when the DC bus is up and no fault.
// - code 30 asserts from table change request while disabled until change completes.
// - code 31 asserts while trickle-current motor heating is active.
// - zero-speed compares measured speed, or demand in V/F, below threshold 180.
// - at-speed asserts when speed error is below band, default 60.
// - set-speed asserts when speed, or demand in V/F, exceeds 1800 default.
// - code 8 asserts when speed is below the zero-speed threshold.
// - code 9 asserts when speed lies within the at-speed band.
// - code 10 asserts when speed passes the set-speed threshold.
//
// The register addresses and strobed register access were chosen for this implementation.

package dos_pkg;

  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned SPD_W   = 16;
  localparam int unsigned NUM_OUT = 4;
  localparam int unsigned SEL_W   = 5;
  localparam int unsigned FLG_W   = 5;

  // Flag positions of the comparison unit
  localparam int unsigned FLG_ZERO    = 0;
  localparam int unsigned FLG_AT_SPD  = 1;
  localparam int unsigned FLG_SET_SPD = 2;
  localparam int unsigned FLG_AT_POS  = 3;
  localparam int unsigned FLG_PROC    = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADR_SEL     = 4'h0;
  localparam logic [ADDR_W-1:0] ADR_ZSPD    = 4'h1;
  localparam logic [ADDR_W-1:0] ADR_BAND    = 4'h2;
  localparam logic [ADDR_W-1:0] ADR_SETSPD  = 4'h3;
  localparam logic [ADDR_W-1:0] ADR_PTOL    = 4'h4;
  localparam logic [ADDR_W-1:0] ADR_PWIN    = 4'h5;
  localparam logic [ADDR_W-1:0] ADR_NET     = 4'h6;
  localparam logic [ADDR_W-1:0] ADR_STATUS  = 4'h7;

  // Status word layout
  localparam int unsigned ST_OUT_LSB = 0;
  localparam int unsigned ST_TBL_BIT = 4;
  localparam int unsigned ST_FLG_LSB = 8;

  // Reset values
  localparam logic [SPD_W-1:0] ZSPD_RST   = 16'h00b4;
  localparam logic [SPD_W-1:0] BAND_RST   = 16'h003c;
  localparam logic [SPD_W-1:0] SETSPD_RST = 16'h0708;
  localparam logic [SPD_W-1:0] PTOL_RST   = 16'h0064;
  localparam logic [SPD_W-1:0] PWIN_RST   = 16'h000a;
  localparam logic [SEL_W-1:0] SEL_RST    = 5'h00;

  // Selection codes handled here
  localparam logic [SEL_W-1:0] SEL_ZERO    = 5'h08;
  localparam logic [SEL_W-1:0] SEL_AT_SPD  = 5'h09;
  localparam logic [SEL_W-1:0] SEL_SET_SPD = 5'h0a;
  localparam logic [SEL_W-1:0] SEL_BRAKE   = 5'h0f;
  localparam logic [SEL_W-1:0] SEL_FOLD    = 5'h10;
  localparam logic [SEL_W-1:0] SEL_FAULT   = 5'h11;
  localparam logic [SEL_W-1:0] SEL_ALARM   = 5'h12;
  localparam logic [SEL_W-1:0] SEL_CMD_FWD = 5'h13;
  localparam logic [SEL_W-1:0] SEL_CMD_REV = 5'h14;
  localparam logic [SEL_W-1:0] SEL_MOT_FWD = 5'h15;
  localparam logic [SEL_W-1:0] SEL_MOT_REV = 5'h16;
  localparam logic [SEL_W-1:0] SEL_PROC    = 5'h17;
  localparam logic [SEL_W-1:0] SEL_NET     = 5'h18;
  localparam logic [SEL_W-1:0] SEL_AT_POS  = 5'h19;
  localparam logic [SEL_W-1:0] SEL_MOVING  = 5'h1a;
  localparam logic [SEL_W-1:0] SEL_PLC     = 5'h1b;
  localparam logic [SEL_W-1:0] SEL_RTC     = 5'h1c;
  localparam logic [SEL_W-1:0] SEL_PWR_UP  = 5'h1d;
  localparam logic [SEL_W-1:0] SEL_TBL_SW  = 5'h1e;
  localparam logic [SEL_W-1:0] SEL_HEATER  = 5'h1f;

  typedef enum logic {
    TS_IDLE,
    TS_ACTIVE
  } dos_tbl_st_t;

endpackage

`timescale 1ns/10ps
`default_nettype none

module dos_top
  import dos_pkg::*;
(
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    arst_n,
  // Register port
  input  wire logic [ADDR_W-1:0]       reg_addr,
  input  wire logic [DATA_W-1:0]       reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [DATA_W-1:0]            reg_rdata,
  // Drive control status levels
  input  wire logic                    vf_mode,
  input  wire logic                    brake_on,
  input  wire logic                    foldback_on,
  input  wire logic                    fault_trip,
  input  wire logic                    alarm_on,
  input  wire logic                    run_fwd_cmd,
  input  wire logic                    run_rev_cmd,
  input  wire logic                    motor_fwd,
  input  wire logic                    motor_rev,
  input  wire logic                    bus_up,
  input  wire logic                    drive_enabled,
  input  wire logic                    tbl_switch_req,
  input  wire logic                    tbl_switch_done,
  input  wire logic                    heater_on,
  // Output levels owned by other units
  input  wire logic [NUM_OUT-1:0]      plc_out,
  input  wire logic [NUM_OUT-1:0]      rtc_out,
  // Measurements, signed
  input  wire logic signed [SPD_W-1:0] motor_speed,
  input  wire logic signed [SPD_W-1:0] speed_demand,
  input  wire logic signed [SPD_W-1:0] speed_ref,
  input  wire logic signed [SPD_W-1:0] process_error,
  input  wire logic signed [SPD_W-1:0] position_error,
  // Programmable outputs
  output logic [NUM_OUT-1:0]           dout
);

  typedef struct packed {
    logic [NUM_OUT-1:0][SEL_W-1:0] sel;
    logic [SPD_W-1:0]              zspd;
    logic [SPD_W-1:0]              band;
    logic [SPD_W-1:0]              setspd;
    logic [SPD_W-1:0]              ptol;
    logic [SPD_W-1:0]              pwin;
    logic [NUM_OUT-1:0]            net;
    dos_tbl_st_t                   tbl;
    logic [NUM_OUT-1:0]            dout;
    logic [DATA_W-1:0]             rdata;
  } dos_st_t;

  dos_st_t            st_r;
  dos_st_t            st_nxt;
  logic [1:0]         rst_sync_r;
  logic               rst_n;
  logic [FLG_W-1:0]   flags;
  logic               tbl_busy;
  logic               tbl_arm;
  wire  [NUM_OUT-1:0] cond;

  // Reset enters asynchronously but is released on the clock
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  assign rst_n = rst_sync_r[1];

  // A table request only counts while the drive is disabled
  assign tbl_arm  = tbl_switch_req && !drive_enabled;
  assign tbl_busy = st_r.tbl == TS_ACTIVE;

  dos_speed_cmp u_cmp (
    .clock                   (clock),
    .rst_n                   (rst_n),
    .standstill_speed_limit  (st_r.zspd),
    .speed_match_band        (st_r.band),
    .set_speed_limit         (st_r.setspd),
    .process_error_tolerance (st_r.ptol),
    .position_window         (st_r.pwin),
    .vf_mode                 (vf_mode),
    .motor_speed             (motor_speed),
    .speed_demand            (speed_demand),
    .speed_ref               (speed_ref),
    .process_error           (process_error),
    .position_error          (position_error),
    .flags                   (flags)
  );

  // One decoder serves every output; unhandled codes hold the output low
  // Levels come in as arguments: a continuous assignment does not see signals read inside a function
  function automatic logic sel_cond(
    input logic [SEL_W-1:0] code,
    input logic [FLG_W-1:0] f,
    input logic             net_bit,
    input logic             plc_bit,
    input logic             rtc_bit,
    input logic             tbl_on,
    input logic             vf,
    input logic             brk,
    input logic             fold,
    input logic             flt,
    input logic             alm,
    input logic             cfwd,
    input logic             crev,
    input logic             mfwd,
    input logic             mrev,
    input logic             bus,
    input logic             heat
  );
    case (code)
      SEL_ZERO:    sel_cond = f[FLG_ZERO];
      SEL_AT_SPD:  sel_cond = f[FLG_AT_SPD];
      SEL_SET_SPD: sel_cond = f[FLG_SET_SPD];
      SEL_BRAKE:   sel_cond = brk;
      SEL_FOLD:    sel_cond = fold & vf;
      SEL_FAULT:   sel_cond = flt;
      SEL_ALARM:   sel_cond = alm;
      SEL_CMD_FWD: sel_cond = cfwd;
      SEL_CMD_REV: sel_cond = crev;
      SEL_MOT_FWD: sel_cond = mfwd;
      SEL_MOT_REV: sel_cond = mrev;
      SEL_PROC:    sel_cond = f[FLG_PROC];
      SEL_NET:     sel_cond = net_bit;
      SEL_AT_POS:  sel_cond = f[FLG_AT_POS];
      SEL_MOVING:  sel_cond = ~f[FLG_AT_POS];
      SEL_PLC:     sel_cond = plc_bit;
      SEL_RTC:     sel_cond = rtc_bit;
      SEL_PWR_UP:  sel_cond = bus & ~flt;
      SEL_TBL_SW:  sel_cond = tbl_on;
      SEL_HEATER:  sel_cond = heat;
      default:     sel_cond = 1'b0;
    endcase
  endfunction

  // One decoder copy per output, all settling in the same cycle
  for (genvar g = 0; g < NUM_OUT; g++)
  begin : g_cond
    assign cond[g] = sel_cond(st_r.sel[g],
                              flags,
                              st_r.net[g],
                              plc_out[g],
                              rtc_out[g],
                              tbl_busy,
                              vf_mode,
                              brake_on,
                              foldback_on,
                              fault_trip,
                              alarm_on,
                              run_fwd_cmd,
                              run_rev_cmd,
                              motor_fwd,
                              motor_rev,
                              bus_up,
                              heater_on);
  end

  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.rdata = '0;

    // Table change tracker; a request in the finishing cycle restarts it
    case (st_r.tbl)
      TS_IDLE:
      begin
        if (tbl_arm)
          st_nxt.tbl = TS_ACTIVE;
      end
      TS_ACTIVE:
      begin
        if (tbl_switch_done && !tbl_arm)
          st_nxt.tbl = TS_IDLE;
      end
      default:
        st_nxt.tbl = TS_IDLE;
    endcase

    // Outputs are recomputed every cycle from live conditions
    st_nxt.dout = cond;

    // Thresholds are taken as written; range checking is left to software
    if (reg_wr)
    begin
      case (reg_addr)
        ADR_SEL:    st_nxt.sel    = reg_wdata[NUM_OUT*SEL_W-1:0];
        ADR_ZSPD:   st_nxt.zspd   = reg_wdata[SPD_W-1:0];
        ADR_BAND:   st_nxt.band   = reg_wdata[SPD_W-1:0];
        ADR_SETSPD: st_nxt.setspd = reg_wdata[SPD_W-1:0];
        ADR_PTOL:   st_nxt.ptol   = reg_wdata[SPD_W-1:0];
        ADR_PWIN:   st_nxt.pwin   = reg_wdata[SPD_W-1:0];
        ADR_NET:    st_nxt.net    = reg_wdata[NUM_OUT-1:0];
        default:    st_nxt.net    = st_r.net;
      endcase
    end

    // Read data lives for one cycle only; the idle value is zero
    if (reg_rd)
    begin
      case (reg_addr)
        ADR_SEL:    st_nxt.rdata = DATA_W'(st_r.sel);
        ADR_ZSPD:   st_nxt.rdata = DATA_W'(st_r.zspd);
        ADR_BAND:   st_nxt.rdata = DATA_W'(st_r.band);
        ADR_SETSPD: st_nxt.rdata = DATA_W'(st_r.setspd);
        ADR_PTOL:   st_nxt.rdata = DATA_W'(st_r.ptol);
        ADR_PWIN:   st_nxt.rdata = DATA_W'(st_r.pwin);
        ADR_NET:    st_nxt.rdata = DATA_W'(st_r.net);
        ADR_STATUS:
        begin
          st_nxt.rdata[ST_OUT_LSB +: NUM_OUT] = st_r.dout;
          st_nxt.rdata[ST_TBL_BIT]            = tbl_busy;
          st_nxt.rdata[ST_FLG_LSB +: FLG_W]   = flags;
        end
        default:    st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r        <= '0;
      st_r.sel    <= {NUM_OUT{SEL_RST}};
      st_r.zspd   <= ZSPD_RST;
      st_r.band   <= BAND_RST;
      st_r.setspd <= SETSPD_RST;
      st_r.ptol   <= PTOL_RST;
      st_r.pwin   <= PWIN_RST;
      st_r.tbl    <= TS_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  assign dout      = st_r.dout;
  assign reg_rdata = st_r.rdata;

endmodule

`default_nettype wire

// [sim/dos_chk_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module dos_chk
  import dos_pkg::*;
(
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               arst_n,
  // Register port
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [DATA_W-1:0]  reg_rdata,
  // Status levels
  input  wire logic               vf_mode,
  input  wire logic               brake_on,
  input  wire logic               foldback_on,
  input  wire logic               fault_trip,
  input  wire logic               bus_up,
  input  wire logic               drive_enabled,
  input  wire logic               tbl_switch_req,
  input  wire logic [NUM_OUT-1:0] plc_out,
  // Outputs
  input  wire logic [NUM_OUT-1:0] dout
);
  logic [DATA_W-1:0] sel_r;
  logic [DATA_W-1:0] net_r;
  logic [1:0]        age_r;
  logic              ok;
  logic [SEL_W-1:0]  c0;
  logic [SEL_W-1:0]  c1;
  // Shadow the selection and network words, the only register state these checks read
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
    begin
      sel_r <= '0;
      net_r <= '0;
      age_r <= 2'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == ADR_SEL) sel_r <= reg_wdata;
      if (reg_wr && reg_addr == ADR_NET) net_r <= reg_wdata;
      if (age_r != 2'h3) age_r <= age_r + 2'h1;
    end
  // Internal reset lags by two flops, so hold off until it has cleared
  assign ok = (age_r == 2'h3);
  assign c0 = sel_r[4:0];
  assign c1 = sel_r[9:5];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  chk_brake_follow: assert property (ok && c0 == SEL_BRAKE |=> dout[0] == $past(brake_on))
    else $error("brake output mismatch");
  chk_fold_gate: assert property (ok && c0 == SEL_FOLD |=> dout[0] == $past(foldback_on && vf_mode))
    else $error("foldback output mismatch");
  chk_fault_follow: assert property (ok && c0 == SEL_FAULT |=> dout[0] == $past(fault_trip))
    else $error("fault output mismatch");
  chk_net_follow: assert property (ok && c0 == SEL_NET |=> dout[0] == $past(net_r[0]))
    else $error("network output mismatch");
  chk_plc_pass: assert property (ok && c1 == SEL_PLC |=> dout[1] == $past(plc_out[1]))
    else $error("plc output mismatch");
  chk_power_up: assert property (ok && c0 == SEL_PWR_UP |=> dout[0] == $past(bus_up && !fault_trip))
    else $error("power up output mismatch");
  chk_tbl_set: assert property (ok && c0 == SEL_TBL_SW && !drive_enabled && tbl_switch_req ##1 c0 == SEL_TBL_SW
    |=> dout[0])
    else $error("table switch output late");
  chk_idle_codes: assert property (ok && c0 inside {[5'h00:5'h07], [5'h0b:5'h0e]} |=> !dout[0])
    else $error("unused code drove output");
  chk_rdata_gap: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data outside its slot");
  cover property (ok && c0 == SEL_TBL_SW && dout[0]);
  cover property (ok && c0 == SEL_BRAKE && dout[0]);
  cover property (ok && c0 == SEL_NET && dout[0]);
endmodule

bind dos_top dos_chk dos_chk_inst (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .vf_mode, .brake_on, .foldback_on, .fault_trip, .bus_up, .drive_enabled, .tbl_switch_req, .plc_out, .dout);
`default_nettype wire

// [sim/dos_relay.sv]
`timescale 1ns/10ps
`default_nettype none
module dos_relay
  import dos_pkg::*;
(
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // Coils from the drive, contacts to the machine
  input  wire logic [NUM_OUT-1:0] coil,
  output logic [NUM_OUT-1:0]      contact
);
  // Contacts pick up one clock after the coil, a crude stand-in for relay travel
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      contact <= '0;
    else
      contact <= coil;
endmodule
`default_nettype wire

// [sim/tb_dos_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_dos_top
  import dos_pkg::*;
;
  typedef struct packed {
    logic vf; logic [15:0] ms; logic [15:0] sd; logic [15:0] sr; logic [15:0] pe; logic [15:0] po;
    logic [19:0] sel; logic [3:0] exp;
  } dos_case_t;
  localparam logic [19:0] S1 = {SEL_PROC, SEL_SET_SPD, SEL_AT_SPD, SEL_ZERO};
  localparam logic [19:0] S2 = {SEL_MOVING, SEL_AT_POS, SEL_MOVING, SEL_AT_POS};
  logic                    clock, arst_n, reg_wr, reg_rd, vf_mode, brake_on, foldback_on, fault_trip;
  logic                    alarm_on, run_fwd_cmd, run_rev_cmd, motor_fwd, motor_rev, bus_up, v;
  logic                    drive_enabled, tbl_switch_req, tbl_switch_done, heater_on;
  logic [ADDR_W-1:0]       reg_addr;
  logic [DATA_W-1:0]       reg_wdata, reg_rdata, rv;
  logic [NUM_OUT-1:0]      plc_out, rtc_out, dout, contact, pat;
  logic signed [SPD_W-1:0] motor_speed, speed_demand, speed_ref, process_error, position_error;
  logic [SEL_W-1:0]        c;
  int                      miscompares, checks_done, cyc;
  logic [SEL_W-1:0] codes [13] = '{SEL_BRAKE, SEL_FOLD, SEL_FAULT, SEL_ALARM, SEL_CMD_FWD, SEL_CMD_REV,
    SEL_MOT_FWD, SEL_MOT_REV, SEL_NET, SEL_PLC, SEL_RTC, SEL_PWR_UP, SEL_HEATER};
  logic [DATA_W-1:0] rexp [8] = '{32'(SEL_RST), 32'(ZSPD_RST), 32'(BAND_RST), 32'(SETSPD_RST),
    32'(PTOL_RST), 32'(PWIN_RST), 32'h0, 32'h0};
  dos_case_t tc [9] = '{
    '{1'b0, 16'h00b3, 16'h0, 16'h00c8, 16'h0064, 16'h0, S1, 4'b0011},
    '{1'b0, 16'hff4c, 16'h0, 16'hff88, 16'hff9b, 16'h0, S1, 4'b1000},
    '{1'b0, 16'h0709, 16'h0, 16'h0709, 16'h0, 16'h0, S1, 4'b0110},
    '{1'b0, 16'h0708, 16'h0, 16'h06cd, 16'h0, 16'h0, S1, 4'b0010},
    '{1'b1, 16'h1388, 16'h000a, 16'h000a, 16'h0, 16'h0, S1, 4'b0011},
    '{1'b1, 16'h1388, 16'h000a, 16'h000a, 16'h0, 16'h0, S2, 4'b1010},
    '{1'b0, 16'h00b4, 16'h0, 16'h0, 16'h0, 16'hfff6, S2, 4'b0101},
    '{1'b0, 16'hff4c, 16'h0, 16'h0, 16'h0, 16'h000b, S2, 4'b1010},
    '{1'b0, 16'h00b5, 16'h0, 16'h0, 16'h0, 16'h000a, S2, 4'b1010}};

  dos_top dos_top_inst (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .vf_mode,
    .brake_on, .foldback_on, .fault_trip, .alarm_on, .run_fwd_cmd, .run_rev_cmd, .motor_fwd, .motor_rev,
    .bus_up, .drive_enabled, .tbl_switch_req, .tbl_switch_done, .heater_on, .plc_out, .rtc_out,
    .motor_speed, .speed_demand, .speed_ref, .process_error, .position_error, .dout);
  dos_relay dos_relay_inst (.clock, .rst_n(arst_n), .coil(dout), .contact);

  always #50 clock = ~clock;

  task automatic wrap_up();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic drive(input logic [SEL_W-1:0] k, input logic b, input logic [NUM_OUT-1:0] p);
    @(posedge clock);
    case (k)
      SEL_BRAKE:   brake_on <= b;
      SEL_FOLD:    foldback_on <= b;
      SEL_FAULT:   fault_trip <= b;
      SEL_ALARM:   alarm_on <= b;
      SEL_CMD_FWD: run_fwd_cmd <= b;
      SEL_CMD_REV: run_rev_cmd <= b;
      SEL_MOT_FWD: motor_fwd <= b;
      SEL_MOT_REV: motor_rev <= b;
      SEL_PLC:     plc_out <= p;
      SEL_RTC:     rtc_out <= p;
      SEL_PWR_UP:  bus_up <= b;
      SEL_HEATER:  heater_on <= b;
      default:     ;
    endcase
  endtask

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  initial
  begin
    {clock, arst_n, reg_wr, reg_rd, vf_mode, brake_on, foldback_on, fault_trip, alarm_on} = '0;
    {run_fwd_cmd, run_rev_cmd, motor_fwd, motor_rev, bus_up, drive_enabled, heater_on} = '0;
    {tbl_switch_req, tbl_switch_done, plc_out, rtc_out, reg_addr, reg_wdata} = '0;
    {motor_speed, speed_demand, speed_ref, process_error, position_error} = '0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    wr(4'h9, 32'hffff_ffff);
    for (int i = 0; i < 8; i++)
    begin
      rd((i == 7) ? 4'h8 : 4'(i), rv);
      chk(rv, rexp[i]);
    end
    chk(32'(dout), 32'h0);
    @(posedge clock);
    vf_mode <= 1'b1;
    foreach (codes[i])
    begin
      c = codes[i];
      wr(ADR_SEL, {12'h0, {4{c}}});
      for (int j = 0; j < 2; j++)
      begin
        v   = (j == 0);
        pat = v ? 4'h5 : 4'ha;
        if (c == SEL_NET) wr(ADR_NET, 32'(pat));
        else drive(c, v, pat);
        hold(2);
        chk(32'(dout), (c == SEL_NET || c == SEL_PLC || c == SEL_RTC) ? 32'(pat) : {28'h0, {4{v}}});
      end
    end
    @(posedge clock);
    {vf_mode, foldback_on, bus_up, fault_trip} <= 4'b0111;
    wr(ADR_SEL, {12'h0, {4{SEL_FOLD}}});
    hold(2);
    chk(32'(dout), 32'h0);
    wr(ADR_SEL, {12'h0, {4{SEL_PWR_UP}}});
    hold(2);
    chk(32'(dout), 32'h0);
    foreach (tc[i])
    begin
      wr(ADR_SEL, {12'h0, tc[i].sel});
      @(posedge clock);
      {vf_mode, motor_speed, speed_demand, speed_ref, process_error, position_error} <=
        {tc[i].vf, tc[i].ms, tc[i].sd, tc[i].sr, tc[i].pe, tc[i].po};
      hold(3);
      chk(32'(dout), 32'(tc[i].exp));
    end
    wr(ADR_SEL, {12'h0, S1});
    wr(ADR_ZSPD, 32'h0000_00b3);
    @(posedge clock);
    {vf_mode, motor_speed, speed_ref} <= {1'b0, 16'h00b3, 16'h00b3};
    hold(3);
    chk(32'(dout[0]), 32'h0);
    rd(ADR_ZSPD, rv);
    chk(rv, 32'h0000_00b3);
    wr(ADR_SEL, {12'h0, {4{SEL_TBL_SW}}});
    @(posedge clock);
    {drive_enabled, tbl_switch_req} <= 2'b11;
    @(posedge clock);
    tbl_switch_req <= 1'b0;
    hold(2);
    chk(32'(dout), 32'h0);
    @(posedge clock);
    {drive_enabled, tbl_switch_req} <= 2'b01;
    @(posedge clock);
    tbl_switch_req <= 1'b0;
    hold(2);
    chk(32'(dout), 32'hf);
    rd(ADR_STATUS, rv);
    chk(32'(rv[4:0]), 32'h1f);
    chk(32'(rv[12:8]), 32'h0a);
    chk(32'(contact), 32'hf);
    @(posedge clock);
    tbl_switch_done <= 1'b1;
    @(posedge clock);
    tbl_switch_done <= 1'b0;
    hold(3);
    chk(32'(dout), 32'h0);
    chk(32'(contact), 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
